// ---- hw/t1_radio_alarm_monitor.sv ----
// T1 line and radio alarm monitor with errored-second counting.
// How it works
// - Panel lamps and alarm register share bits.
// - Red alarm when no line signal.
// - Bipolar-violation alarm when violations arrive.
// - Yellow received flashes the combined lamp.
// - Blue code holds the combined lamp on.
// - Radio link alarm while link down.
// - Code lock alarm while data unsynchronised.
// - Carrier lock alarm while frequency unsynchronised.
// - Mux frame alarm while mux unframed.
// - AMI: violation or framing error errs second.
// - ESF: violation or CRC error errs second.
// - AMI severe: 1544 violations or 8 framing.
// - ESF severe: 1544 violations or 320 CRC.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module t1_radio_alarm_monitor #(
  parameter int unsigned SEC_CYC   = t1_alarm_pkg::SECOND_CYCLES,
  parameter int unsigned FLASH_CYC = t1_alarm_pkg::FLASH_CYCLES,
  parameter int unsigned CNT_W     = 16
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [2:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  input  wire logic        line_clk_i,
  input  wire logic        line_pos_i,
  input  wire logic        line_neg_i,
  input  wire logic        yellow_rx_i,
  input  wire logic        fbit_err_i,
  input  wire logic        crc_err_i,
  input  wire logic        radio_link_up_i,
  input  wire logic        code_locked_i,
  input  wire logic        carrier_locked_i,
  input  wire logic        mux_framed_i,
  output logic             red_led_o,
  output logic             bpv_led_o,
  output logic             remote_or_blue_alarm_o,
  output logic             radio_link_alarm_o,
  output logic             code_lock_led_o,
  output logic             carrier_lock_led_o,
  output logic             mux_frame_lock_alarm_o,
  output logic             irq_o
);
  import t1_alarm_pkg::*;

  // ----------------------------------------
  // Line synchronisers and edge finding
  // ----------------------------------------
  // The line clock is only sampled; 160 ns periods give eight samples each.
  logic [2:0] lclk_q;
  logic [1:0] pos_q;
  logic [1:0] neg_q;
  logic       bit_stb;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lclk_q <= 3'h0;
      pos_q  <= 2'h0;
      neg_q  <= 2'h0;
    end else begin
      lclk_q <= {lclk_q[1:0], line_clk_i};
      pos_q  <= {pos_q[0], line_pos_i};
      neg_q  <= {neg_q[0], line_neg_i};
    end
  end
  assign bit_stb = lclk_q[1] & ~lclk_q[2];

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [1:0] control_q;
  logic       esf_mode;
  logic       acc_q;
  logic       wr_ok;
  assign esf_mode = control_q[0];
  assign wr_ok    = write_i & acc_q & byteenable_i[0];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      control_q <= CONTROL_RESET;
    end else if (wr_ok && address_i == ADDR_CONTROL) begin
      control_q <= writedata_i[1:0];
    end
  end

  // ----------------------------------------
  // Line decoding: loss, violations, blue code
  // ----------------------------------------
  logic       mark;
  logic       last_pol_q;
  logic       pol_known_q;
  logic       bpv_pulse;
  logic [7:0] zero_run_q;
  logic       los_q;
  logic [11:0] ones_run_q;
  logic       zero_seen_q;
  logic       blue_q;
  assign mark      = pos_q[1] | neg_q[1];
  // No polarity is known until the first mark, so that mark is never a violation.
  assign bpv_pulse = bit_stb & mark & pol_known_q & (pos_q[1] ? last_pol_q : ~last_pol_q)
                     & ~(pos_q[1] & neg_q[1]);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_pol_q  <= 1'b0;
      pol_known_q <= 1'b0;
    end else if (bit_stb && mark) begin
      last_pol_q  <= pos_q[1];
      pol_known_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      zero_run_q <= 8'h00;
      los_q      <= 1'b1;
    end else if (bit_stb) begin
      if (mark) begin
        zero_run_q <= 8'h00;
        los_q      <= 1'b0;
      end else if (zero_run_q == 8'(LOS_ZERO_BITS - 1)) begin
        los_q      <= 1'b1;
      end else begin
        zero_run_q <= zero_run_q + 8'h01;
      end
    end
  end
  // A run restarts at the second zero, keeping the first one tolerated.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ones_run_q  <= 12'h000;
      zero_seen_q <= 1'b0;
      blue_q      <= 1'b0;
    end else if (bit_stb) begin
      if (!mark && zero_seen_q) begin
        ones_run_q <= 12'h000;
        blue_q     <= 1'b0;
      end else begin
        zero_seen_q <= zero_seen_q | ~mark;
        if (ones_run_q == 12'(BLUE_RUN_BITS - 1)) begin
          blue_q <= 1'b1;
        end else begin
          ones_run_q <= ones_run_q + 12'h001;
        end
      end
      if (!mark && zero_seen_q) begin
        zero_seen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // One-second timebase and tallies
  // ----------------------------------------
  logic [31:0] sec_cnt_q;
  logic        sec_end;
  logic [10:0] bpv_tally_q;
  logic [8:0]  err_tally_q;
  logic        err_pulse;
  logic        errored;
  logic        severe;
  logic        bpv_prev_q;
  assign sec_end   = sec_cnt_q == SEC_CYC - 1;
  assign err_pulse = esf_mode ? crc_err_i : fbit_err_i;
  assign errored   = bpv_tally_q != 11'h000 || err_tally_q != 9'h000;
  assign severe    = bpv_tally_q >= 11'(SES_BPV_LIMIT)
                     || (esf_mode ? err_tally_q >= 9'(SES_CRC_LIMIT)
                                  : err_tally_q >= 9'(SES_FBE_LIMIT));
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sec_cnt_q <= 32'h0000_0000;
    end else begin
      sec_cnt_q <= sec_end ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
    end
  end
  // Tallies saturate at SES_BPV_LIMIT and SES_CRC_LIMIT (also in AMI mode); only the threshold matters.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bpv_tally_q <= 11'h000;
      err_tally_q <= 9'h000;
      bpv_prev_q  <= 1'b0;
    end else if (sec_end) begin
      // A pulse in the boundary cycle opens the next second instead of being lost.
      bpv_tally_q <= {10'h000, bpv_pulse};
      err_tally_q <= {8'h00, err_pulse};
      bpv_prev_q  <= bpv_tally_q != 11'h000 || bpv_pulse;
    end else begin
      if (bpv_pulse && bpv_tally_q < 11'(SES_BPV_LIMIT)) begin
        bpv_tally_q <= bpv_tally_q + 11'h001;
      end
      if (err_pulse && err_tally_q < 9'(SES_CRC_LIMIT)) begin
        err_tally_q <= err_tally_q + 9'h001;
      end
    end
  end

  // ----------------------------------------
  // Errored and severely errored second counters
  // ----------------------------------------
  logic [CNT_W-1:0] es_cnt_q;
  logic [CNT_W-1:0] ses_cnt_q;
  logic             es_evt;
  logic             ses_evt;
  assign es_evt  = sec_end & errored;
  assign ses_evt = sec_end & severe;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      es_cnt_q <= '0;
    end else if (wr_ok && address_i == ADDR_ES_CNT) begin
      es_cnt_q <= '0;
    end else if (es_evt && ~&es_cnt_q) begin
      es_cnt_q <= es_cnt_q + CNT_W'(1);
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ses_cnt_q <= '0;
    end else if (wr_ok && address_i == ADDR_SES_CNT) begin
      ses_cnt_q <= '0;
    end else if (ses_evt && ~&ses_cnt_q) begin
      ses_cnt_q <= ses_cnt_q + CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Alarm vector, shared by register and lamps
  // ----------------------------------------
  logic [NUM_EVENTS-1:0] alarm_d;
  logic [NUM_EVENTS-1:0] alarm_q;
  always_comb begin
    alarm_d              = '0;
    alarm_d[BIT_LOS]     = los_q;
    alarm_d[BIT_BPV]     = bpv_prev_q | (bpv_tally_q != 11'h000);
    alarm_d[BIT_YELLOW]  = yellow_rx_i & ~blue_q;
    alarm_d[BIT_BLUE]    = blue_q;
    alarm_d[BIT_LINK]    = ~radio_link_up_i;
    alarm_d[BIT_CODE]    = ~code_locked_i;
    alarm_d[BIT_CARRIER] = ~carrier_locked_i;
    alarm_d[BIT_MUX]     = ~mux_framed_i;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // ----------------------------------------
  // Flash timer and lamp drive
  // ----------------------------------------
  logic [31:0] flash_cnt_q;
  logic        flash_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == FLASH_CYC - 1) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
  end
  // Lamps read the same flops the register reads, so only the combined lamp, gated by the yellow flash, can differ from them.
  assign red_led_o              = alarm_q[BIT_LOS];
  assign bpv_led_o              = alarm_q[BIT_BPV];
  assign remote_or_blue_alarm_o = alarm_q[BIT_BLUE]
                                  | (alarm_q[BIT_YELLOW] & flash_q);
  assign radio_link_alarm_o     = alarm_q[BIT_LINK];
  assign code_lock_led_o        = alarm_q[BIT_CODE];
  assign carrier_lock_led_o     = alarm_q[BIT_CARRIER];
  assign mux_frame_lock_alarm_o = alarm_q[BIT_MUX];

  // ----------------------------------------
  // Sticky events, mask and interrupt
  // ----------------------------------------
  logic [NUM_EVENTS-1:0] set_evt;
  logic [NUM_EVENTS-1:0] event_q;
  logic [NUM_EVENTS-1:0] mask_q;
  logic [NUM_EVENTS-1:0] w1c;
  always_comb begin
    set_evt          = alarm_d & ~alarm_q;
    set_evt[BIT_ES]  = es_evt;
    set_evt[BIT_SES] = ses_evt;
  end
  assign w1c = (wr_ok && address_i == ADDR_EVENTS) ? writedata_i[NUM_EVENTS-1:0] : '0;
  // Setting wins over a clear in the same cycle.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      event_q <= '0;
    end else begin
      event_q <= (event_q & ~w1c) | set_evt;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mask_q <= MASK_RESET;
    end else if (write_i && acc_q && address_i == ADDR_MASK) begin
      if (byteenable_i[0]) begin
        mask_q[7:0] <= writedata_i[7:0];
      end
      if (byteenable_i[1]) begin
        mask_q[9:8] <= writedata_i[9:8];
      end
    end
  end
  assign irq_o = |(event_q & mask_q);

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // Every access waits exactly one cycle; data is ready when waitrequest drops.
  logic [31:0] rd_d;
  logic [31:0] readdata_q;
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (address_i)
      ADDR_CONTROL: rd_d[1:0]            = control_q;
      ADDR_ALARMS:  rd_d[NUM_EVENTS-1:0] = alarm_q;
      ADDR_EVENTS:  rd_d[NUM_EVENTS-1:0] = event_q;
      ADDR_MASK:    rd_d[NUM_EVENTS-1:0] = mask_q;
      ADDR_ES_CNT:  rd_d[CNT_W-1:0]      = es_cnt_q;
      ADDR_SES_CNT: rd_d[CNT_W-1:0]      = ses_cnt_q;
      default:      rd_d                 = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q      <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end else begin
      acc_q <= (read_i | write_i) & ~acc_q;
      if (read_i && !acc_q) begin
        readdata_q <= rd_d;
      end
    end
  end
  assign waitrequest_o = (read_i | write_i) & ~acc_q;
  assign readdata_o    = readdata_q;
endmodule
`default_nettype wire

// ---- hw/t1_alarm_pkg.sv ----
// Constants shared by the T1 alarm and performance monitor.
`default_nettype none
package t1_alarm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned FLASH_NS      = 250000000;
  localparam int unsigned FLASH_CYCLES  = FLASH_NS / CLK_PERIOD_NS;
  // ----------------------------------------
  // Line thresholds
  // ----------------------------------------
  localparam int unsigned BLUE_RUN_BITS  = 2316;
  localparam int unsigned LOS_ZERO_BITS  = 175;
  localparam int unsigned SES_BPV_LIMIT  = 1544;
  localparam int unsigned SES_FBE_LIMIT  = 8;
  localparam int unsigned SES_CRC_LIMIT  = 320;
  // ----------------------------------------
  // Register word addresses
  // ----------------------------------------
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_ALARMS  = 3'h1;
  localparam logic [2:0] ADDR_EVENTS  = 3'h2;
  localparam logic [2:0] ADDR_MASK    = 3'h3;
  localparam logic [2:0] ADDR_ES_CNT  = 3'h4;
  localparam logic [2:0] ADDR_SES_CNT = 3'h5;
  // ----------------------------------------
  // Alarm and event bit positions
  // ----------------------------------------
  localparam int unsigned BIT_LOS     = 0;
  localparam int unsigned BIT_BPV     = 1;
  localparam int unsigned BIT_YELLOW  = 2;
  localparam int unsigned BIT_BLUE    = 3;
  localparam int unsigned BIT_LINK    = 4;
  localparam int unsigned BIT_CODE    = 5;
  localparam int unsigned BIT_CARRIER = 6;
  localparam int unsigned BIT_MUX     = 7;
  localparam int unsigned BIT_ES      = 8;
  localparam int unsigned BIT_SES     = 9;
  localparam int unsigned NUM_EVENTS  = 10;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [9:0] MASK_RESET    = 10'h000;
endpackage
`default_nettype wire

// ---- testbench/t1_alarm_props.sv ----
// Port-level assertions for the T1 alarm monitor.
`timescale 1ns/100ps
`default_nettype none
module t1_alarm_props (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [2:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        line_pos_i,
  input wire logic        line_neg_i,
  input wire logic        radio_link_up_i,
  input wire logic        code_locked_i,
  input wire logic        carrier_locked_i,
  input wire logic        mux_framed_i,
  input wire logic        red_led_o,
  input wire logic        bpv_led_o,
  input wire logic        radio_link_alarm_o,
  input wire logic        code_lock_led_o,
  input wire logic        carrier_lock_led_o,
  input wire logic        mux_frame_lock_alarm_o
);
  import t1_alarm_pkg::*;
  // Quiet-line cycle count; it saturates so a dead line never wraps back to zero.
  logic [10:0] quiet_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) quiet_q <= 11'h000;
    else if (line_pos_i || line_neg_i) quiet_q <= 11'h000;
    else if (quiet_q != 11'h7FF) quiet_q <= quiet_q + 11'h001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  link_alarm_a: assert property (!$past(sys_rst_i) |->
    radio_link_alarm_o == !$past(radio_link_up_i)) else $error("Link alarm wrong.");
  code_alarm_a: assert property ($fell(code_locked_i) |=> code_lock_led_o)
    else $error("Code lock alarm missing.");
  carrier_alarm_a: assert property ($rose(carrier_locked_i) |=> !carrier_lock_led_o)
    else $error("Carrier lock alarm stuck.");
  mux_alarm_a: assert property (mux_framed_i [*2] |-> !mux_frame_lock_alarm_o)
    else $error("Mux frame alarm while framed.");
  one_wait_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("More than one wait cycle.");
  panel_match_a: assert property (read_i && !waitrequest_o && address_i == ADDR_ALARMS |->
    {readdata_o[7:4], readdata_o[1:0]} == $past({mux_frame_lock_alarm_o, carrier_lock_led_o,
    code_lock_led_o, radio_link_alarm_o, bpv_led_o, red_led_o})) else $error("Panel differs.");
  los_clear_a: assert property ($rose(line_pos_i) |-> ##[1:16] !red_led_o)
    else $error("Red alarm stays after a mark.");
  los_set_a: assert property (quiet_q == 11'h5DC |-> red_led_o)
    else $error("Red alarm missing on a dead line.");
  cover property (read_i && !waitrequest_o && address_i == ADDR_ALARMS);
  cover property (red_led_o ##1 !red_led_o);
  cover property ($fell(radio_link_up_i) ##2 radio_link_alarm_o);
endmodule
bind t1_radio_alarm_monitor t1_alarm_props props (.clk_i, .sys_rst_i, .address_i, .read_i,
  .write_i, .readdata_o, .waitrequest_o, .line_pos_i, .line_neg_i, .radio_link_up_i,
  .code_locked_i, .carrier_locked_i, .mux_framed_i, .red_led_o, .bpv_led_o,
  .radio_link_alarm_o, .code_lock_led_o, .carrier_lock_led_o, .mux_frame_lock_alarm_o);
`default_nettype wire

// ---- testbench/t1_line_model.sv ----
// Behavioural T1 line source feeding the monitor's line inputs.
`timescale 1ns/100ps
`default_nettype none
module t1_line_model (
  input  wire logic [1:0] mode_i,
  output logic            line_clk_o,
  output logic            pos_o,
  output logic            neg_o
);
  logic pol_q;
  logic odd_q;
  // A recovered line clock runs free, so only the marks carry the pattern.
  initial begin
    {line_clk_o, pos_o, neg_o, pol_q, odd_q} = 5'h00;
    #37;
    forever #80 line_clk_o = ~line_clk_o;
  end
  // Marks change on the falling edge so they are settled at the sampling edge.
  always @(negedge line_clk_o) begin
    odd_q <= ~odd_q;
    if (mode_i == 2'h3) begin
      {pos_o, neg_o} <= 2'h2;
    end else if (mode_i == 2'h2 || (mode_i == 2'h1 && odd_q)) begin
      {pos_o, neg_o} <= {pol_q, ~pol_q};
      pol_q <= ~pol_q;
    end else begin
      {pos_o, neg_o} <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/t1_radio_alarm_monitor_test.sv ----
// Self-checking bench for the T1 radio alarm monitor.
`timescale 1ns/100ps
`default_nettype none
module t1_radio_alarm_monitor_test;
  import t1_alarm_pkg::*;
  localparam int SEC = 2000;
  localparam logic [4:0][3:0] FB   = {4'h0, 4'h0, 4'h8, 4'h8, 4'h7};
  localparam logic [4:0][8:0] CR   = {9'h140, 9'h13F, 9'h000, 9'h000, 9'h008};
  localparam logic [4:0][3:0] ESX  = {4'h4, 4'h3, 4'h2, 4'h2, 4'h1};
  localparam logic [4:0][3:0] SESX = {4'h2, 4'h1, 4'h1, 4'h1, 4'h0};
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [2:0]  address_i = 3'h0;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic        yellow_rx_i = 1'b0;
  logic        fbit_err_i = 1'b0;
  logic        crc_err_i = 1'b0;
  logic [3:0]  radio_ok = 4'hF;
  logic [1:0]  mode = 2'h0;
  logic [31:0] readdata_o;
  logic [31:0] rd;
  logic        waitrequest_o, line_clk_i, line_pos_i, line_neg_i, irq_o;
  logic        red_led_o, bpv_led_o, remote_or_blue_alarm_o;
  wire [3:0]   radio_led;
  wire [3:0]   watch = {irq_o, remote_or_blue_alarm_o, bpv_led_o, red_led_o};
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          k, n, t0;
  t1_line_model far (.mode_i(mode), .line_clk_o(line_clk_i), .pos_o(line_pos_i),
    .neg_o(line_neg_i));
  t1_radio_alarm_monitor #(.SEC_CYC(SEC), .FLASH_CYC(50)) dut (.clk_i, .sys_rst_i, .address_i,
    .read_i, .write_i, .byteenable_i(4'hF), .writedata_i, .readdata_o, .waitrequest_o,
    .line_clk_i, .line_pos_i, .line_neg_i, .yellow_rx_i, .fbit_err_i, .crc_err_i,
    .radio_link_up_i(radio_ok[0]), .code_locked_i(radio_ok[1]), .carrier_locked_i(radio_ok[2]),
    .mux_framed_i(radio_ok[3]), .red_led_o, .bpv_led_o, .remote_or_blue_alarm_o,
    .radio_link_alarm_o(radio_led[0]), .code_lock_led_o(radio_led[1]),
    .carrier_lock_led_o(radio_led[2]), .mux_frame_lock_alarm_o(radio_led[3]), .irq_o);
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One cycle passes after the release so a following request is a fresh assignment.
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int i;
    {address_i, writedata_i, read_i, write_i} <= {a, wd, !wr, wr};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (waitrequest_o !== 1'b0 && i < 50);
    d = readdata_o;
    if (waitrequest_o !== 1'b0) begin
      check(32'h0, 32'h1);
      summarize();
    end
    {read_i, write_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic wait_on(input int w, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && watch[w] !== lvl; i++) @(posedge clk_i);
    if (watch[w] !== lvl) begin
      check(32'h0, 32'h1);
      summarize();
    end
  endtask
  task automatic edges(input int len, output int e);
    logic prev;
    e = 0;
    prev = watch[2];
    repeat (len) begin
      @(posedge clk_i);
      if (watch[2] !== prev) e++;
      prev = watch[2];
    end
  endtask
  task automatic errs(input int f, input int c);
    for (int i = 0; i < f || i < c; i++) begin
      {fbit_err_i, crc_err_i} <= {i < f, i < c};
      @(posedge clk_i);
    end
    {fbit_err_i, crc_err_i} <= 2'h0;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, ADDR_CONTROL, 32'h0, rd);
    check(rd, {30'h0, CONTROL_RESET});
    bus(1'b0, ADDR_MASK, 32'h0, rd);
    check(rd, {22'h0, MASK_RESET});
    bus(1'b0, 3'h7, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, ADDR_ALARMS, 32'h0, rd);
    check(rd, 32'h1);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      radio_ok <= 4'hF ^ (4'h1 << k);
      repeat (3) @(posedge clk_i);
      bus(1'b0, ADDR_ALARMS, 32'h0, rd);
      check(rd[7:4], 4'h1 << k);
      check(radio_led, 4'h1 << k);
    end
    radio_ok <= 4'hF;
    mode <= 2'h1;
    wait_on(0, 1'b0, 100);
    mode <= 2'h3;
    wait_on(1, 1'b1, 100);
    bus(1'b0, ADDR_ALARMS, 32'h0, rd);
    check(rd[1:0], 2'h2);
    mode <= 2'h0;
    wait_on(0, 1'b1, 1600);
    $display("test line done");
    mode <= 2'h2;
    repeat (18000) @(posedge clk_i);
    check(remote_or_blue_alarm_o, 1'b0);
    wait_on(2, 1'b1, 1200);
    yellow_rx_i <= 1'b1;
    edges(200, n);
    check(n, 0);
    mode <= 2'h1;
    repeat (100) @(posedge clk_i);
    edges(400, n);
    check(n >= 7 && n <= 9, 1'b1);
    yellow_rx_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    check(remote_or_blue_alarm_o, 1'b0);
    $display("test blue done");
    bus(1'b1, ADDR_EVENTS, 32'h3FF, rd);
    bus(1'b1, ADDR_MASK, 32'h10, rd);
    radio_ok <= 4'hC;
    wait_on(3, 1'b1, 10);
    bus(1'b0, ADDR_EVENTS, 32'h0, rd);
    check(rd & 32'hFF, 32'h30);
    bus(1'b1, ADDR_EVENTS, 32'h10, rd);
    check(irq_o, 1'b0);
    radio_ok <= 4'hF;
    $display("test events done");
    bus(1'b1, ADDR_EVENTS, 32'h3FF, rd);
    bus(1'b1, ADDR_MASK, 32'h100, rd);
    errs(1, 0);
    wait_on(3, 1'b1, SEC + 20);
    t0 = cyc;
    bus(1'b1, ADDR_ES_CNT, 32'h0, rd);
    bus(1'b1, ADDR_SES_CNT, 32'h0, rd);
    for (k = 0; k < 5; k++) begin
      bus(1'b1, ADDR_CONTROL, (k >= 2) ? 32'h1 : 32'h0, rd);
      errs(FB[k], CR[k]);
      while (cyc < t0 + (k + 1) * SEC + 8) @(posedge clk_i);
      bus(1'b0, ADDR_ES_CNT, 32'h0, rd);
      check(rd, ESX[k]);
      bus(1'b0, ADDR_SES_CNT, 32'h0, rd);
      check(rd, SESX[k]);
    end
    $display("test seconds done");
    summarize();
  end
endmodule
`default_nettype wire
